// file: hdl/prcd_consts.svh
`ifndef PRCD_CONSTS_SVH
`define PRCD_CONSTS_SVH

// ----------------------------------------
// Configuration word field positions
// ----------------------------------------
`define PRCD_MEM_LOOP_LSB    8
`define PRCD_MEM_LOOP_MSB    9
`define PRCD_MEM_MULT_LSB    10
`define PRCD_MEM_MULT_MSB    14
`define PRCD_MEM_SYNC_BIT    184
`define PRCD_MEM_RATE_BIT    232
`define PRCD_MEM_RSV_BIT     234

// ----------------------------------------
// Platform multiplier codes
// ----------------------------------------
`define PRCD_PLAT_MIN        5'h05
`define PRCD_PLAT_MAX        5'h0c

// ----------------------------------------
// Cluster multiplier codes
// ----------------------------------------
`define PRCD_CLU_MIN         5'h08
`define PRCD_CLU_MAX         5'h0c
`define PRCD_CLU_X14         5'h0e
`define PRCD_CLU_X15         5'h0f
`define PRCD_CLU_X16         5'h10

// ----------------------------------------
// Memory multiplier codes
// ----------------------------------------
`define PRCD_MEM_SYNC_CODE   5'h01

// ----------------------------------------
// Core source select codes
// ----------------------------------------
`define PRCD_SEL_P1_DIV1     4'h0
`define PRCD_SEL_P1_DIV2     4'h1
`define PRCD_SEL_P2_DIV1     4'h4
`define PRCD_SEL_P2_DIV2     4'h5
`define PRCD_SEL_P3_DIV1     4'h8
`define PRCD_SEL_P3_DIV2     4'h9
`define PRCD_SEL_P4_DIV1     4'hc
`define PRCD_SEL_P4_DIV2     4'hd

// ----------------------------------------
// Counts
// ----------------------------------------
`define PRCD_NUM_CLUSTERS    4
`define PRCD_NUM_CORES       8
`define PRCD_LOW_CORES       4

`endif

// file: hdl/prcd_pkg.sv
package prcd_pkg;

  // ----------------------------------------
  // Source PLL of a core clock
  // ----------------------------------------
  typedef enum logic [1:0]
  {
    PRCD_SRC_ONE   = 2'b00,
    PRCD_SRC_TWO   = 2'b01,
    PRCD_SRC_THREE = 2'b10,
    PRCD_SRC_FOUR  = 2'b11
  } prcd_src_t;

  // ----------------------------------------
  // Memory PLL reference
  // ----------------------------------------
  typedef enum logic
  {
    PRCD_REF_SYSTEM   = 1'b0,
    PRCD_REF_PLATFORM = 1'b1
  } prcd_ref_t;

endpackage

// file: hdl/prcd_core_sel.sv
`timescale 1ns/1ns
`include "prcd_consts.svh"

module prcd_core_sel
  import prcd_pkg::*;
#(
  parameter bit UPPER = 1'b0
)
(
  input  wire logic       sel_code,
  input  wire logic [3:0] sel_field,
  output prcd_src_t       src,
  output logic            halved,
  output logic            invalid
);

  // ----------------------------------------
  // Source select decode
  // ----------------------------------------
  always_comb
  begin
    src     = PRCD_SRC_ONE;
    halved  = 1'b0;
    invalid = 1'b0;
    if (!UPPER)
    begin
      unique case (sel_field)
        `PRCD_SEL_P1_DIV1: src = PRCD_SRC_ONE;
        `PRCD_SEL_P1_DIV2:
        begin
          src    = PRCD_SRC_ONE;
          halved = 1'b1;
        end
        `PRCD_SEL_P2_DIV1: src = PRCD_SRC_TWO;
        `PRCD_SEL_P2_DIV2:
        begin
          src    = PRCD_SRC_TWO;
          halved = 1'b1;
        end
        `PRCD_SEL_P3_DIV1:
        begin
          src    = PRCD_SRC_THREE;
          halved = 1'b1;
        end
        default: invalid = 1'b1;
      endcase
    end
    else
    begin
      unique case (sel_field)
        `PRCD_SEL_P1_DIV1: src = PRCD_SRC_ONE;
        `PRCD_SEL_P3_DIV1: src = PRCD_SRC_THREE;
        `PRCD_SEL_P3_DIV2:
        begin
          src    = PRCD_SRC_THREE;
          halved = 1'b1;
        end
        `PRCD_SEL_P4_DIV1: src = PRCD_SRC_FOUR;
        `PRCD_SEL_P4_DIV2:
        begin
          src    = PRCD_SRC_FOUR;
          halved = 1'b1;
        end
        default: invalid = 1'b1;
      endcase
    end
    if (!sel_code)
    begin
      src     = PRCD_SRC_ONE;
      halved  = 1'b0;
      invalid = 1'b0;
    end
  end

endmodule

// file: hdl/prcd_decoder.sv
`timescale 1ns/1ns
`include "prcd_consts.svh"

module prcd_decoder
  import prcd_pkg::*;
(
  input  wire logic         sys_clk,
  input  wire logic         rst_n,
  input  wire logic         cfg_sample,
  input  wire logic [255:0] reset_configuration_word,
  input  wire logic [4:0]   platform_multiplier_field,
  input  wire logic [1:0]   platform_loop_config_field,
  input  wire logic [19:0]  cluster_multiplier_field,
  input  wire logic [7:0]   cluster_loop_config_field,
  input  wire logic [31:0]  core_source_select_field,
  output logic [4:0]        plat_mult_q,
  output logic [1:0]        plat_loop_q,
  output logic              plat_invalid_q,
  output logic [19:0]       clu_mult_q,
  output logic [7:0]        clu_loop_q,
  output logic [3:0]        clu_invalid_q,
  output logic [15:0]       core_src_q,
  output logic [7:0]        core_halved_q,
  output logic [7:0]        core_invalid_q,
  output logic [4:0]        mem_mult_q,
  output logic [1:0]        mem_loop_q,
  output logic              mem_ref_q,
  output logic              mem_sync_q,
  output logic              mem_invalid_q,
  output logic              cfg_valid_q
);

  // ----------------------------------------
  // Input synchroniser for the sample strobe
  // ----------------------------------------
  logic smp_s1_q;
  logic smp_s2_q;
  logic smp_s3_q;
  logic smp_pulse;

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      smp_s1_q <= 1'b0;
      smp_s2_q <= 1'b0;
      smp_s3_q <= 1'b0;
    end
    else
    begin
      smp_s1_q <= cfg_sample;
      smp_s2_q <= smp_s1_q;
      smp_s3_q <= smp_s2_q;
    end
  end

  assign smp_pulse = smp_s2_q & ~smp_s3_q;

  // ----------------------------------------
  // Memory fields from the configuration word
  // ----------------------------------------
  logic [4:0] mem_field;
  logic [1:0] mem_loop_field;
  logic       sync_mode;
  logic       mode_mismatch;
  logic       rsv_set;

  assign mem_field      =
    reset_configuration_word[`PRCD_MEM_MULT_MSB:`PRCD_MEM_MULT_LSB];
  assign mem_loop_field =
    reset_configuration_word[`PRCD_MEM_LOOP_MSB:`PRCD_MEM_LOOP_LSB];
  assign sync_mode      = reset_configuration_word[`PRCD_MEM_SYNC_BIT];
  assign mode_mismatch  = reset_configuration_word[`PRCD_MEM_SYNC_BIT] !=
                          reset_configuration_word[`PRCD_MEM_RATE_BIT];
  assign rsv_set        = reset_configuration_word[`PRCD_MEM_RSV_BIT];

  // ----------------------------------------
  // Combinational decode
  // ----------------------------------------
  logic       plat_bad;
  logic       mem_bad;
  logic [3:0] clu_bad;

  always_comb
  begin
    plat_bad = (platform_multiplier_field < `PRCD_PLAT_MIN) ||
               (platform_multiplier_field > `PRCD_PLAT_MAX);
    mem_bad  = 1'b1;
    if (sync_mode)
    begin
      mem_bad = (mem_field != `PRCD_MEM_SYNC_CODE);
    end
    else
    begin
      unique case (mem_field)
        5'h05, 5'h06, 5'h08, 5'h09, 5'h0a, 5'h0c, 5'h0d, 5'h10: mem_bad = 1'b0;
        default: mem_bad = 1'b1;
      endcase
    end
    mem_bad = mem_bad | mode_mismatch | rsv_set;
  end

  genvar gi;
  generate
    for (gi = 0; gi < `PRCD_NUM_CLUSTERS; gi++)
    begin : g_clu
      logic [4:0] f;
      assign f = cluster_multiplier_field[gi*5 +: 5];
      assign clu_bad[gi] = !(((f >= `PRCD_CLU_MIN) && (f <= `PRCD_CLU_MAX)) ||
                             (f == `PRCD_CLU_X14) || (f == `PRCD_CLU_X15) ||
                             (f == `PRCD_CLU_X16));
    end
  endgenerate

  // ----------------------------------------
  // Core source select decoders
  // ----------------------------------------
  prcd_src_t  core_src  [8];
  logic [7:0] core_half;
  logic [7:0] core_bad;

  generate
    for (gi = 0; gi < `PRCD_NUM_CORES; gi++)
    begin : g_core
      prcd_core_sel #(
        .UPPER (gi >= `PRCD_LOW_CORES)
      ) u_sel (
        .sel_code  (1'b1),
        .sel_field (core_source_select_field[gi*4 +: 4]),
        .src       (core_src[gi]),
        .halved    (core_half[gi]),
        .invalid   (core_bad[gi])
      );
    end
  endgenerate

  // ----------------------------------------
  // Platform PLL settings
  // ----------------------------------------
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      plat_mult_q    <= 5'h00;
      plat_loop_q    <= 2'h0;
      plat_invalid_q <= 1'b0;
    end
    else if (smp_pulse)
    begin
      plat_mult_q    <= plat_bad ? 5'h00 : platform_multiplier_field;
      plat_loop_q    <= platform_loop_config_field;
      plat_invalid_q <= plat_bad;
    end
  end

  // ----------------------------------------
  // Cluster PLL settings
  // ----------------------------------------
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      clu_mult_q    <= 20'h00000;
      clu_loop_q    <= 8'h00;
      clu_invalid_q <= 4'h0;
    end
    else if (smp_pulse)
    begin
      for (int i = 0; i < `PRCD_NUM_CLUSTERS; i++)
      begin
        clu_mult_q[i*5 +: 5] <= clu_bad[i] ? 5'h00 : cluster_multiplier_field[i*5 +: 5];
      end
      clu_loop_q    <= cluster_loop_config_field;
      clu_invalid_q <= clu_bad;
    end
  end

  // ----------------------------------------
  // Core clock mux settings
  // ----------------------------------------
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      core_src_q     <= 16'h0000;
      core_halved_q  <= 8'h00;
      core_invalid_q <= 8'h00;
    end
    else if (smp_pulse)
    begin
      for (int i = 0; i < `PRCD_NUM_CORES; i++)
      begin
        core_src_q[i*2 +: 2] <= core_bad[i] ? 2'h0 : core_src[i];
      end
      core_halved_q  <= core_half & ~core_bad;
      core_invalid_q <= core_bad;
    end
  end

  // ----------------------------------------
  // Shared memory PLL settings
  // ----------------------------------------
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      mem_mult_q    <= 5'h00;
      mem_loop_q    <= 2'h0;
      mem_ref_q     <= PRCD_REF_SYSTEM;
      mem_sync_q    <= 1'b0;
      mem_invalid_q <= 1'b0;
    end
    else if (smp_pulse)
    begin
      mem_mult_q    <= mem_bad ? 5'h00 : mem_field;
      mem_loop_q    <= mem_loop_field;
      mem_ref_q     <= sync_mode ? PRCD_REF_PLATFORM : PRCD_REF_SYSTEM;
      mem_sync_q    <= sync_mode;
      mem_invalid_q <= mem_bad;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      cfg_valid_q <= 1'b0;
    end
    else if (smp_pulse)
    begin
      cfg_valid_q <= 1'b1;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  AST_PLAT_RANGE: assert property (@(posedge sys_clk) disable iff (!rst_n)
    smp_pulse |=> (plat_invalid_q == ((platform_multiplier_field < 5'h05) ||
                   (platform_multiplier_field > 5'h0c))) || $changed(platform_multiplier_field))
    else $error("Platform reserved flag wrong");

  AST_PLAT_ZERO: assert property (@(posedge sys_clk) disable iff (!rst_n)
    plat_invalid_q |-> plat_mult_q == 5'h00)
    else $error("Reserved platform code drives a factor");

  AST_CLU_ZERO: assert property (@(posedge sys_clk) disable iff (!rst_n)
    clu_invalid_q[0] |-> clu_mult_q[4:0] == 5'h00)
    else $error("Reserved cluster code drives a factor");

  AST_CLU_X13: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (smp_pulse && cluster_multiplier_field[4:0] == 5'h0d) |=> clu_invalid_q[0])
    else $error("Cluster code 13 not flagged");

  AST_LOW_P4: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (core_src_q[1:0] != 2'b11))
    else $error("Low core selected PLL four");

  AST_UP_P2: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (core_src_q[15:14] != 2'b01))
    else $error("High core selected PLL two");

  AST_MEM_REF: assert property (@(posedge sys_clk) disable iff (!rst_n)
    smp_pulse |=> (mem_ref_q == $past(reset_configuration_word[184])))
    else $error("Memory reference mismatches mode");

  AST_MEM_SYNC: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (cfg_valid_q && mem_sync_q && !mem_invalid_q) |-> mem_mult_q == 5'h01)
    else $error("Sync memory factor not one");

  AST_MEM_RSV: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (smp_pulse && reset_configuration_word[234]) |=> mem_invalid_q)
    else $error("Reserved memory bit not flagged");

  AST_SAMPLE_LAT: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $rose(smp_s2_q) |=> cfg_valid_q)
    else $error("Sample not taken");
endmodule

// file: tb/prcd_cfg_src.sv
`timescale 1ns/1ns
// ----------------------------------------
// Configuration source model
// ----------------------------------------
module prcd_cfg_src
#(
  parameter int REF_MHZ = 100
)
(
  input  wire logic [4:0]   plat_code,
  input  wire logic [19:0]  clu_code,
  input  wire logic [4:0]   mem_code,
  input  wire logic         sync_mode,
  input  wire logic         mism,
  input  wire logic         rsv,
  input  wire logic [255:0] filler,
  output logic [255:0]      reset_configuration_word,
  output logic [1:0]        platform_loop_config_field,
  output logic [7:0]        cluster_loop_config_field
);
  int cut;

  always_comb
  begin
    platform_loop_config_field = (REF_MHZ * plat_code >= 667) ? 2'h0 : 2'h1;
    for (int k = 0; k < 4; k++)
    begin
      cluster_loop_config_field[k*2+:2] =
        (REF_MHZ * clu_code[k*5+:5] >= 1000) ? 2'h0 : 2'h1;
    end
    case (mem_code)
      5'h08: cut = 1209;
      5'h09: cut = 1074;
      5'h05, 5'h0a: cut = 967;
      default: cut = 832;
    endcase
    reset_configuration_word = filler;
    if (sync_mode)
      reset_configuration_word[9:8] = (REF_MHZ * plat_code > 600) ? 2'h1 : 2'h0;
    else
      reset_configuration_word[9:8] = (REF_MHZ * 10 > cut) ? 2'h1 : 2'h0;
    reset_configuration_word[14:10] = mem_code;
    reset_configuration_word[184] = sync_mode;
    reset_configuration_word[232] = sync_mode ^ mism;
    reset_configuration_word[234] = rsv;
  end
endmodule

// file: tb/tb_top.sv
`timescale 1ns/1ns
module tb_top;
  import prcd_pkg::*;
  logic         sys_clk, rst_n, cfg_sample, sync_mode, mism, rsv;
  logic [4:0]   plat_code, mem_code;
  logic [19:0]  clu_code;
  logic [31:0]  sel_code;
  logic [255:0] filler, reset_configuration_word;
  logic [1:0]   platform_loop_config_field, plat_loop_q, mem_loop_q;
  logic [7:0]   cluster_loop_config_field, clu_loop_q, core_halved_q, core_invalid_q;
  logic [4:0]   plat_mult_q, mem_mult_q;
  logic [19:0]  clu_mult_q;
  logic [3:0]   clu_invalid_q;
  logic [15:0]  core_src_q, r;
  logic         plat_invalid_q, mem_ref_q, mem_sync_q, mem_invalid_q, cfg_valid_q;
  int           err_count, compares;
  localparam int REF_MHZ      = 100;
  localparam int CORE_MAX_MHZ = 1500;

  prcd_cfg_src #(.REF_MHZ(REF_MHZ)) u_src (.plat_code(plat_code), .clu_code(clu_code),
    .mem_code(mem_code), .sync_mode(sync_mode), .mism(mism), .rsv(rsv), .filler(filler),
    .reset_configuration_word(reset_configuration_word),
    .platform_loop_config_field(platform_loop_config_field),
    .cluster_loop_config_field(cluster_loop_config_field));

  prcd_decoder u_dut (.sys_clk(sys_clk), .rst_n(rst_n), .cfg_sample(cfg_sample),
    .reset_configuration_word(reset_configuration_word),
    .platform_multiplier_field(plat_code),
    .platform_loop_config_field(platform_loop_config_field),
    .cluster_multiplier_field(clu_code),
    .cluster_loop_config_field(cluster_loop_config_field),
    .core_source_select_field(sel_code), .plat_mult_q(plat_mult_q),
    .plat_loop_q(plat_loop_q), .plat_invalid_q(plat_invalid_q), .clu_mult_q(clu_mult_q),
    .clu_loop_q(clu_loop_q), .clu_invalid_q(clu_invalid_q), .core_src_q(core_src_q),
    .core_halved_q(core_halved_q), .core_invalid_q(core_invalid_q),
    .mem_mult_q(mem_mult_q), .mem_loop_q(mem_loop_q), .mem_ref_q(mem_ref_q),
    .mem_sync_q(mem_sync_q), .mem_invalid_q(mem_invalid_q), .cfg_valid_q(cfg_valid_q));

  initial
  begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  // ----------------------------------------
  // Expected values, {invalid, factor}
  // ----------------------------------------
  function automatic logic [15:0] lfsr(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction

  function automatic logic [5:0] exp_plat(input logic [4:0] c);
    return (c >= 5'h05 && c <= 5'h0c) ? {1'b0, c} : 6'h20;
  endfunction

  function automatic logic [5:0] exp_clu(input logic [4:0] c);
    return ((c >= 5'h08 && c <= 5'h0c) || c inside {5'h0e, 5'h0f, 5'h10}) ? {1'b0, c} : 6'h20;
  endfunction

  function automatic logic [5:0] exp_mem(input logic [4:0] c, input logic s, input logic bad);
    logic ok;
    ok = s ? (c == 5'h01) : (c inside {5'h05, 5'h06, 5'h08, 5'h09, 5'h0a, 5'h0c, 5'h0d, 5'h10});
    return (ok && !bad) ? {1'b0, c} : 6'h20;
  endfunction

  // {invalid, halved, source}
  function automatic logic [3:0] exp_sel(input int k, input logic [3:0] c);
    if (k < 4)
      case (c)
        4'h0: return 4'h0;
        4'h1: return 4'h4;
        4'h4: return 4'h1;
        4'h5: return 4'h5;
        4'h8: return 4'h6;
        default: return 4'h8;
      endcase
    case (c)
      4'h0: return 4'h0;
      4'h8: return 4'h2;
      4'h9: return 4'h6;
      4'hc: return 4'h3;
      4'hd: return 4'h7;
      default: return 4'h8;
    endcase
  endfunction

  // ----------------------------------------
  // Compare and closing tasks
  // ----------------------------------------
  task automatic chk_val(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp)
    begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    chk_val({7'h0, got}, {7'h0, exp});
  endtask

  task automatic wrap_up();
    $display("errors %0d compares %0d", err_count, compares);
    if (err_count == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic capture();
    logic [5:0] e;
    @(negedge sys_clk) cfg_sample = 1'b1;
    repeat (3) @(negedge sys_clk);
    cfg_sample = 1'b0;
    repeat (4) @(negedge sys_clk);
    e = exp_plat(plat_code);
    chk_val(8'(plat_mult_q), 8'(e[4:0]));
    chk_bit(plat_invalid_q, e[5]);
    chk_val(8'(plat_loop_q), 8'(platform_loop_config_field));
    for (int k = 0; k < 4; k++)
    begin
      e = exp_clu(clu_code[k*5+:5]);
      chk_val(8'(clu_mult_q[k*5+:5]), 8'(e[4:0]));
      chk_bit(clu_invalid_q[k], e[5]);
      chk_val(8'(clu_loop_q[k*2+:2]), 8'(cluster_loop_config_field[k*2+:2]));
    end
    for (int k = 0; k < 8; k++)
      chk_val(8'({core_invalid_q[k], core_halved_q[k], core_src_q[k*2+:2]}),
              8'(exp_sel(k, sel_code[k*4+:4])));
    e = exp_mem(mem_code, sync_mode, mism | rsv);
    chk_val(8'(mem_mult_q), 8'(e[4:0]));
    chk_bit(mem_invalid_q, e[5]);
    chk_bit(mem_ref_q, sync_mode);
    chk_bit(mem_sync_q, sync_mode);
    chk_val(8'(mem_loop_q), 8'(reset_configuration_word[9:8]));
    chk_bit(cfg_valid_q, 1'b1);
  endtask

  initial
  begin
    #400000;
    err_count++;
    wrap_up();
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    int p;
    {rst_n, cfg_sample, sync_mode, mism, rsv} = 5'h0;
    {plat_code, mem_code, clu_code, sel_code} = '0;
    filler = '0;
    r = 16'hde00;
    repeat (16) @(negedge sys_clk);
    rst_n = 1'b1;
    @(negedge sys_clk);
    chk_bit(cfg_valid_q, 1'b0);
    chk_val(8'(plat_mult_q), 8'h0);
    // Every code of every multiplier and select field, with sync, mismatch and reserved-bit corners
    for (int i = 0; i < 32; i++)
    begin
      plat_code = 5'(i);
      mem_code = 5'(i);
      clu_code = {5'(i + 3), 5'(i + 2), 5'(i + 1), 5'(i)};
      for (int k = 0; k < 8; k++)
        sel_code[k*4+:4] = 4'(i + k);
      sync_mode = (i % 4 == 1);
      mism = (i == 16);
      rsv = (i == 12);
      filler = ~filler;
      capture();
    end
    // Random configurations
    for (int i = 0; i < 40; i++)
    begin
      r = lfsr(r);
      {mism, rsv, sync_mode, mem_code, plat_code} = {r[15:12] == 4'h0, r[15:12] == 4'h1, r[10:0]};
      r = lfsr(r);
      clu_code = {r, r[3:0]};
      r = lfsr(r);
      sel_code[15:0] = r;
      r = lfsr(r);
      sel_code[31:16] = r;
      filler = {16{r}};
      if (!sync_mode && {plat_code, 1'b0} < {1'b0, mem_code})
        plat_code = 5'h0c;
      for (int k = 0; k < 8; k++)
      begin
        p = (k < 4) ? 10 : 0;
        if (sel_code[k*4+:4] == ((k < 4) ? 4'h8 : 4'h0) &&
            REF_MHZ * 10 * clu_code[p+:5] > CORE_MAX_MHZ * 8)
          clu_code[p+:5] = 5'h0c;
      end
      capture();
    end
    // Reset in mid-run clears the captured set
    rst_n = 1'b0;
    repeat (2) @(negedge sys_clk);
    rst_n = 1'b1;
    @(negedge sys_clk);
    chk_bit(cfg_valid_q, 1'b0);
    chk_val(8'(mem_mult_q), 8'h0);
    // Capture again after the mid-run reset
    capture();
    wrap_up();
  end
endmodule
